// File: inc/usart_tx_regs.svh
// register offsets, field positions, reset values and baud constants
// assumes a 32-bit apb slave with one aligned word per register
`ifndef USART_TX_REGS_SVH
`define USART_TX_REGS_SVH

`define OFS_CTRL_STATUS_A 8'h00
`define OFS_CTRL_STATUS_B 8'h04
`define OFS_FRAME_CFG 8'h08
`define OFS_BAUD_DIVISOR 8'h0C
`define OFS_CHAR_DATA 8'h10
`define OFS_TX_STATE 8'h14

// ctrl_status_reg_a
`define A_TXC_BIT 6
`define A_UDRE_BIT 5
`define A_DBL_BIT 1
// ctrl_status_reg_b
`define B_TXC_IE_BIT 6
`define B_UDRE_IE_BIT 5
`define B_RXEN_BIT 4
`define B_TX_ENABLE_BIT_BIT 3
`define B_SIZE2_BIT 2
`define B_NINTH_BIT 0
// frame configuration
`define C_SYNC_BIT 6
`define C_PAR_HI 5
`define C_PAR_LO 4
`define C_STOP2_BIT 3
`define C_SIZE_HI 2
`define C_SIZE_LO 1
`define C_POL_BIT 0

`define RST_SIZE_LO 2'h3
`define RST_BAUD 12'h000
`define SIZE_NINE 3'h7
`define SUB_NORMAL 4'hF
`define SUB_DOUBLE 4'h7

`endif

// File: inc/usart_tx_pkg.sv
// types shared by the transmit path
// assumes usart_tx_regs.svh provides the numeric constants
package usart_tx_pkg;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_START = 5'h02,
		ST_DATA = 5'h04,
		ST_PARITY = 5'h08,
		ST_STOP = 5'h10
	} tx_state_e;

endpackage

// File: hdl/sync3.sv
// three-stage input synchroniser with agreement filter
// assumes d is asynchronous to clk
`timescale 1ns/1ps

module sync3 (
	input wire logic clk,
	input wire logic resetn,
	input wire logic d,
	output logic level_q
);

	logic s1_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// a change counts only once stages two and three agree
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			level_q <= 1'b1;
		end else if (s2_q == s3_q) begin
			level_q <= s3_q;
		end
	end

endmodule

// File: hdl/usart_tx.sv
// usart transmit path with apb registers and receiver pin override
// assumes apb master on clk, pins driven through external port muxes
//
// Summary of operation
// RL1 - tx enable hands the serial output pin to the transmitter.
// RL2 - synchronous mode takes the external clock pin as shift clock.
// RL3 - writing the data register puts the character into the buffer.
// RL4 - buffer loads shifter when idle or right after the last stop bit.
// RL5 - frame goes out at baud divisor rate, or external clock rate.
// RL6 - unused upper data bits are ignored for short characters.
// RL7 - ninth bit is written first and sent as the top data bit.
// RL8 - buffer-empty flag is one when empty, zero while data waits.
// RL9 - software writes zero to the buffer-empty position.
// RL10 - buffer-empty request holds while enabled and flag set.
// RL11 - a data register write clears the buffer-empty flag.
// RL12 - handler must write data or drop the buffer-empty enable.
// RL13 - complete flag sets when frame done and buffer empty.
// RL14 - complete flag clears on interrupt service or written one.
// RL15 - complete request rises with the flag while enabled.
// RL16 - enabled parity goes after the last data bit, before stop.
// RL17 - disabling waits until shifter and buffer are both empty.
// RL18 - once really disabled the output pin returns to the port.
// RL19 - rx enable hands the serial input pin to the receiver.
// RL20 - synchronous receiver uses the external clock pin.
// RL21 - software sets baud, mode and format before sending.
// RL22 - start low, 5 to 9 data lsb first, parity, 1-2 stops.
// RL23 - parity is xor of data bits, inverted for odd.
// RL24 - bit period 16 or 8 times divisor plus one clocks.
// RL25 - sync data changes on rising edge, falling if polarity set.
// RL26 - reset leaves buffer empty, complete clear, enables off.
`timescale 1ns/1ps
`include "usart_tx_regs.svh"

module usart_tx
	import usart_tx_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic tx_complete_irq_ack,
	input wire logic ext_shift_clock_pin,
	input wire logic serial_in_pin,
	output logic serial_out_pin,
	output logic tx_pin_override,
	output logic clock_pin_override,
	output logic rx_pin_override,
	output logic rx_serial_data,
	output logic irq_buffer_empty,
	output logic irq_tx_complete
);

	// configuration
	logic double_speed_bit_q;
	logic tx_complete_irq_en_q;
	logic tx_buffer_empty_irq_en_q;
	logic rx_enable_bit_q;
	logic tx_enable_bit_q;
	logic tx_ninth_bit_q;
	logic [2:0] char_size_field_q;
	logic sync_mode_select_q;
	logic [1:0] parity_mode_q;
	logic stop_bits_select_q;
	logic clock_polarity_bit_q;
	logic [11:0] baud_divisor_q;

	// transmit state
	logic tx_complete_flag_q;
	logic [8:0] buf_data_q;
	logic buf_full_q;
	logic tx_active_q;
	tx_state_e state_q;
	logic [8:0] shreg_q;
	logic [3:0] bit_idx_q;
	logic [3:0] nbits_q;
	logic parity_q;
	logic stop2_q;
	logic stop_second_q;
	logic [11:0] div_cnt_q;
	logic [3:0] sub_cnt_q;
	logic xck_prev_q;

	logic xck_level;
	logic rxd_level;
	logic setup;
	logic wr_en;
	logic data_wr;
	logic tick;
	logic tick_async;
	logic xck_edge;
	logic frame_end;
	logic load;
	logic [3:0] nbits;
	logic [8:0] masked;
	logic [3:0] sub_max;
	logic [31:0] rdata;
	logic hit;

	sync3 u_sync_xck (
		.clk(clk),
		.resetn(resetn),
		.d(ext_shift_clock_pin),
		.level_q(xck_level)
	);

	sync3 u_sync_rxd (
		.clk(clk),
		.resetn(resetn),
		.d(serial_in_pin),
		.level_q(rxd_level)
	);

	// apb: no wait state, so read data is captured in the setup cycle
	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pready & pwrite;
	assign data_wr = wr_en & (paddr == `OFS_CHAR_DATA);

	always_comb begin
		rdata = 32'h0000_0000;
		hit = 1'b1;
		case (paddr)
			`OFS_CTRL_STATUS_A: begin
				rdata[`A_TXC_BIT] = tx_complete_flag_q;
				rdata[`A_UDRE_BIT] = ~buf_full_q; // [RL8]
				rdata[`A_DBL_BIT] = double_speed_bit_q;
			end
			`OFS_CTRL_STATUS_B: begin
				rdata[`B_TXC_IE_BIT] = tx_complete_irq_en_q;
				rdata[`B_UDRE_IE_BIT] = tx_buffer_empty_irq_en_q;
				rdata[`B_RXEN_BIT] = rx_enable_bit_q;
				rdata[`B_TX_ENABLE_BIT_BIT] = tx_enable_bit_q;
				rdata[`B_SIZE2_BIT] = char_size_field_q[2];
				rdata[`B_NINTH_BIT] = tx_ninth_bit_q;
			end
			`OFS_FRAME_CFG: begin
				rdata[`C_SYNC_BIT] = sync_mode_select_q;
				rdata[`C_PAR_HI:`C_PAR_LO] = parity_mode_q;
				rdata[`C_STOP2_BIT] = stop_bits_select_q;
				rdata[`C_SIZE_HI:`C_SIZE_LO] = char_size_field_q[1:0];
				rdata[`C_POL_BIT] = clock_polarity_bit_q;
			end
			`OFS_BAUD_DIVISOR: begin
				rdata[11:0] = baud_divisor_q;
			end
			`OFS_CHAR_DATA: begin
				rdata = 32'h0000_0000;
			end
			`OFS_TX_STATE: begin
				rdata[0] = tx_active_q;
				rdata[1] = (state_q != ST_IDLE);
			end
			default: begin
				hit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= setup & ~pready;
			pslverr <= setup & ~hit;
			if (setup) begin
				prdata <= pwrite ? 32'h0000_0000 : rdata;
			end
		end
	end

	// configuration writes; the buffer-empty bit position is read-only
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin // [RL26]
			double_speed_bit_q <= 1'b0;
			tx_complete_irq_en_q <= 1'b0;
			tx_buffer_empty_irq_en_q <= 1'b0;
			rx_enable_bit_q <= 1'b0;
			tx_enable_bit_q <= 1'b0;
			tx_ninth_bit_q <= 1'b0;
			char_size_field_q <= {1'b0, `RST_SIZE_LO};
			sync_mode_select_q <= 1'b0;
			parity_mode_q <= 2'h0;
			stop_bits_select_q <= 1'b0;
			clock_polarity_bit_q <= 1'b0;
			baud_divisor_q <= `RST_BAUD;
		end else if (wr_en) begin
			case (paddr)
				`OFS_CTRL_STATUS_A: begin
					double_speed_bit_q <= pwdata[`A_DBL_BIT];
				end
				`OFS_CTRL_STATUS_B: begin
					tx_complete_irq_en_q <= pwdata[`B_TXC_IE_BIT];
					tx_buffer_empty_irq_en_q <= pwdata[`B_UDRE_IE_BIT];
					rx_enable_bit_q <= pwdata[`B_RXEN_BIT];
					tx_enable_bit_q <= pwdata[`B_TX_ENABLE_BIT_BIT];
					char_size_field_q[2] <= pwdata[`B_SIZE2_BIT];
					tx_ninth_bit_q <= pwdata[`B_NINTH_BIT]; // [RL7]
				end
				`OFS_FRAME_CFG: begin
					sync_mode_select_q <= pwdata[`C_SYNC_BIT];
					parity_mode_q <= pwdata[`C_PAR_HI:`C_PAR_LO];
					stop_bits_select_q <= pwdata[`C_STOP2_BIT];
					char_size_field_q[1:0] <= pwdata[`C_SIZE_HI:`C_SIZE_LO];
					clock_polarity_bit_q <= pwdata[`C_POL_BIT];
				end
				`OFS_BAUD_DIVISOR: begin
					baud_divisor_q <= pwdata[11:0];
				end
				default: begin
				end
			endcase
		end
	end

	// character length and masking of unused upper bits
	always_comb begin
		case (char_size_field_q)
			3'h0: nbits = 4'h5;
			3'h1: nbits = 4'h6;
			3'h2: nbits = 4'h7;
			`SIZE_NINE: nbits = 4'h9;
			default: nbits = 4'h8;
		endcase
		masked = buf_data_q & ~(9'h1FF << nbits); // [RL6]
	end

	// bit timing: divisor stage then 16 or 8 sub-steps
	assign sub_max = double_speed_bit_q ? `SUB_DOUBLE : `SUB_NORMAL;
	assign tick_async = (div_cnt_q == baud_divisor_q) &&
		(sub_cnt_q == sub_max); // [RL24]
	assign xck_edge = clock_polarity_bit_q ? (xck_prev_q & ~xck_level) :
		(~xck_prev_q & xck_level); // [RL25]
	// synchronous slave shifts on external edges only [RL2] [RL5]
	assign tick = (state_q != ST_IDLE) &&
		(sync_mode_select_q ? xck_edge : tick_async);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			div_cnt_q <= 12'h000;
			sub_cnt_q <= 4'h0;
			xck_prev_q <= 1'b1;
		end else begin
			xck_prev_q <= xck_level;
			if (load || tick_async || state_q == ST_IDLE) begin
				div_cnt_q <= 12'h000;
				if (load || state_q == ST_IDLE || sub_cnt_q == sub_max) begin
					sub_cnt_q <= 4'h0;
				end else begin
					sub_cnt_q <= sub_cnt_q + 4'h1;
				end
			end else if (div_cnt_q == baud_divisor_q) begin
				div_cnt_q <= 12'h000;
				sub_cnt_q <= sub_cnt_q + 4'h1;
			end else begin
				div_cnt_q <= div_cnt_q + 12'h001;
			end
		end
	end

	assign frame_end = (state_q == ST_STOP) && tick &&
		(!stop2_q || stop_second_q);
	assign load = tx_active_q && buf_full_q &&
		((state_q == ST_IDLE) || frame_end); // [RL4]

	// transmit buffer; a write in the load cycle keeps the new character
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			buf_data_q <= 9'h000;
			buf_full_q <= 1'b0;
		end else begin
			if (data_wr) begin
				buf_data_q <= {tx_ninth_bit_q, pwdata[7:0]}; // [RL3] [RL7]
			end
			buf_full_q <= (buf_full_q & ~load) | data_wr; // [RL11]
		end
	end

	// enable takes hold at once, release waits for an empty path
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tx_active_q <= 1'b0;
		end else if (tx_enable_bit_q) begin
			tx_active_q <= 1'b1; // [RL1]
		end else if (state_q == ST_IDLE && !buf_full_q) begin
			tx_active_q <= 1'b0; // [RL17]
		end
	end

	// frame sequencer
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q <= ST_IDLE;
			shreg_q <= 9'h000;
			bit_idx_q <= 4'h0;
			nbits_q <= 4'h8;
			parity_q <= 1'b0;
			stop2_q <= 1'b0;
			stop_second_q <= 1'b0;
			serial_out_pin <= 1'b1;
		end else if (load) begin
			state_q <= ST_START;
			shreg_q <= masked;
			nbits_q <= nbits;
			parity_q <= (^masked) ^ parity_mode_q[0]; // [RL23]
			stop2_q <= stop_bits_select_q;
			stop_second_q <= 1'b0;
			bit_idx_q <= 4'h0;
			serial_out_pin <= 1'b0; // [RL22]
		end else if (tick) begin
			case (state_q)
				ST_START: begin
					state_q <= ST_DATA;
					serial_out_pin <= shreg_q[0]; // [RL22]
				end
				ST_DATA: begin
					if (bit_idx_q == nbits_q - 4'h1) begin
						if (parity_mode_q[1]) begin
							state_q <= ST_PARITY;
							serial_out_pin <= parity_q; // [RL16]
						end else begin
							state_q <= ST_STOP;
							serial_out_pin <= 1'b1;
						end
					end else begin
						bit_idx_q <= bit_idx_q + 4'h1;
						shreg_q <= {1'b0, shreg_q[8:1]};
						serial_out_pin <= shreg_q[1];
					end
				end
				ST_PARITY: begin
					state_q <= ST_STOP;
					serial_out_pin <= 1'b1;
				end
				ST_STOP: begin
					if (stop2_q && !stop_second_q) begin
						stop_second_q <= 1'b1;
					end else begin
						state_q <= ST_IDLE;
					end
					serial_out_pin <= 1'b1;
				end
				default: begin
					state_q <= ST_IDLE;
					serial_out_pin <= 1'b1;
				end
			endcase
		end
	end

	// complete flag: a new completion wins over any clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tx_complete_flag_q <= 1'b0;
		end else if (frame_end && !load) begin
			tx_complete_flag_q <= 1'b1; // [RL13]
		end else if (tx_complete_irq_ack ||
			(wr_en && paddr == `OFS_CTRL_STATUS_A &&
			pwdata[`A_TXC_BIT])) begin
			tx_complete_flag_q <= 1'b0; // [RL14]
		end
	end

	// requests and pin ownership, registered for clean outputs
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_buffer_empty <= 1'b0;
			irq_tx_complete <= 1'b0;
			tx_pin_override <= 1'b0;
			clock_pin_override <= 1'b0;
			rx_pin_override <= 1'b0;
			rx_serial_data <= 1'b1;
		end else begin
			// level request; only new data or a cleared enable drops it
			irq_buffer_empty <= tx_buffer_empty_irq_en_q &
				~buf_full_q & ~data_wr; // [RL10]
			irq_tx_complete <= tx_complete_irq_en_q &
				tx_complete_flag_q; // [RL15]
			tx_pin_override <= tx_active_q; // [RL1] [RL18]
			clock_pin_override <= sync_mode_select_q &
				(tx_active_q | rx_enable_bit_q); // [RL2] [RL20]
			rx_pin_override <= rx_enable_bit_q; // [RL19]
			rx_serial_data <= rx_enable_bit_q ? rxd_level : 1'b1;
		end
	end

endmodule

// File: bench/usart_tx_properties.sv
// port checker for the usart transmit path
// assumes binding onto usart_tx, one clock domain
`timescale 1ns/1ps
`include "usart_tx_regs.svh"
module usart_tx_properties (
	input wire logic clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic tx_complete_irq_ack,
	input wire logic ext_shift_clock_pin,
	input wire logic serial_in_pin,
	input wire logic serial_out_pin,
	input wire logic tx_pin_override,
	input wire logic clock_pin_override,
	input wire logic rx_pin_override,
	input wire logic rx_serial_data,
	input wire logic irq_buffer_empty,
	input wire logic irq_tx_complete
);
	default clocking
		@(posedge clk);
	endclocking
	default disable iff (!resetn);
	logic wr;
	assign wr = psel && penable && pready && pwrite;
	property p_ready_next;
		psel && !penable |=> pready;
	endproperty
	a_ready_next: assert property (p_ready_next)
		else $error("no ready after setup");
	property p_empty_drop;
		wr && paddr == `OFS_CHAR_DATA |=> !irq_buffer_empty;
	endproperty
	a_empty_drop: assert property (p_empty_drop)
		else $error("empty request stays");
	property p_empty_hold;
		irq_buffer_empty && !wr && !$past(wr) |=> irq_buffer_empty;
	endproperty
	a_empty_hold: assert property (p_empty_hold)
		else $error("empty request lost");
	property p_done_hold;
		// request is registered, so a clear shows two cycles later
		irq_tx_complete && !tx_complete_irq_ack &&
			!$past(tx_complete_irq_ack) && !wr && !$past(wr) |=>
			irq_tx_complete;
	endproperty
	a_done_hold: assert property (p_done_hold)
		else $error("complete request lost");
	property p_ack_clear;
		tx_complete_irq_ack && irq_tx_complete |-> ##2 !irq_tx_complete;
	endproperty
	a_ack_clear: assert property (p_ack_clear)
		else $error("complete not cleared");
	// shortest asynchronous bit is 8 clocks, so no cell is narrower
	property p_bit_width;
		$changed(serial_out_pin) |=> $stable(serial_out_pin)[*7];
	endproperty
	a_bit_width: assert property (p_bit_width)
		else $error("bit too short");
	property p_own_start;
		$fell(serial_out_pin) |-> tx_pin_override;
	endproperty
	a_own_start: assert property (p_own_start)
		else $error("frame without pin");
	property p_rx_idle;
		!rx_pin_override && !$past(rx_pin_override) |-> rx_serial_data;
	endproperty
	a_rx_idle: assert property (p_rx_idle)
		else $error("rx data while off");
	c_ack: cover property (tx_complete_irq_ack && irq_tx_complete);
	c_err: cover property (pslverr);
	c_off: cover property ($fell(tx_pin_override));
endmodule

bind usart_tx usart_tx_properties u_usart_tx_properties (.clk, .resetn,
	.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.tx_complete_irq_ack, .ext_shift_clock_pin, .serial_in_pin,
	.serial_out_pin, .tx_pin_override, .clock_pin_override,
	.rx_pin_override, .rx_serial_data, .irq_buffer_empty, .irq_tx_complete);

// File: bench/serial_station.sv
// remote station: decodes frames from the line into a queue
// assumes async frames of bitp clocks a bit; clock pin held still
`timescale 1ns/1ps
module serial_station (
	input wire logic clk,
	input wire logic line,
	input wire logic [15:0] bitp,
	input wire logic [3:0] nb,
	input wire logic pe,
	output logic xck,
	output logic sin
);
	int got[$];
	int v;
	// rx input keeps moving so a stale level never passes
	initial begin
		xck = 1'b1;
		sin = 1'b1;
		forever #370 sin = ~sin;
	end
	// mid-cell sampling, start through first stop only
	initial begin
		forever begin
			@(negedge line);
			repeat (bitp / 2) @(posedge clk);
			v = 0;
			for (int i = 0; i < nb + pe + 2; i++) begin
				v[i] = line;
				if (i < nb + pe + 1)
					repeat (bitp) @(posedge clk);
			end
			got.push_back(v);
		end
	end
endmodule

// File: bench/testbench.sv
// self-checking bench for the usart transmit path
// assumes serial_station decodes the line at the set bit period
`timescale 1ns/1ps
`include "usart_tx_regs.svh"
module testbench;
	logic clk, resetn, psel, penable, pwrite, ack, err_q;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd_q;
	logic pready, pslverr, xck, sin, sout, tpo, cpo, rpo, rsd, ibe, itc;
	logic [15:0] bitp;
	logic [3:0] nb;
	logic pe;
	int errors, checks_done, v, k, n;
	int sz[5] = '{0, 1, 2, 3, 7};
	int pm[5] = '{2, 3, 0, 2, 3};
	int dv[5] = '{0, 1, 0, 2, 0};
	int db[5] = '{0, 1, 1, 0, 0};
	usart_tx u_usart_tx (.clk, .resetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .tx_complete_irq_ack(ack),
		.ext_shift_clock_pin(xck), .serial_in_pin(sin),
		.serial_out_pin(sout), .tx_pin_override(tpo),
		.clock_pin_override(cpo), .rx_pin_override(rpo),
		.rx_serial_data(rsd), .irq_buffer_empty(ibe),
		.irq_tx_complete(itc));
	serial_station u_serial_station (.clk, .line(sout), .bitp, .nb, .pe,
		.xck, .sin);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input string s, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask
	// frame model: start, masked data lsb first, parity, stop
	function automatic int frm(int d, int n, int p);
		int m;
		m = d & ((1 << n) - 1);
		if (p[1])
			m |= ((^m) ^ p[0]) << n;
		return (m << 1) | (1 << (n + 1 + p[1]));
	endfunction
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// request holds until ready is sampled high at a rising edge
		do @(posedge clk);
		while (pready !== 1'b1);
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk("register", e, rd_q);
	endtask
	task automatic frames(input int a, input int b, input int p);
		chk("count", 2, u_serial_station.got.size());
		if (u_serial_station.got.size() == 2) begin
			chk("frame", frm(a, nb, p), u_serial_station.got.pop_front());
			chk("frame", frm(b, nb, p), u_serial_station.got.pop_front());
		end
	endtask
	task automatic report_and_stop();
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial begin
		#500000;
		errors++;
		report_and_stop();
	end
	initial begin
		{psel, penable, pwrite, ack} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		{errors, checks_done} = 0;
		bitp = 16'd16;
		nb = 4'd8;
		pe = 1'b0;
		resetn = 1'b0;
		void'($urandom(11));
		repeat (20) @(posedge clk);
		resetn <= 1'b1;
		rd(`OFS_CTRL_STATUS_A, 32'h20);
		rd(`OFS_CTRL_STATUS_B, 32'h0);
		rd(`OFS_FRAME_CFG, 32'h6);
		bus(1'b0, 8'h18, 32'h0);
		chk("slverr", 1, err_q);
		chk("rx idle", 1, rsd);
		chk("clock pin", 0, cpo);
		for (k = 0; k < 5; k++) begin
			n = sz[k] == 7 ? 9 : sz[k] + 5;
			v = $urandom & 32'h1FF;
			bitp <= 16'((db[k] ? 8 : 16) * (dv[k] + 1));
			nb <= 4'(n);
			pe <= 1'(pm[k] >> 1);
			bus(1'b1, `OFS_BAUD_DIVISOR, dv[k]);
			bus(1'b1, `OFS_CTRL_STATUS_A, db[k] << 1);
			bus(1'b1, `OFS_FRAME_CFG,
				pm[k] << 4 | (k & 2) << 2 | (sz[k] & 3) << 1);
			bus(1'b1, `OFS_CTRL_STATUS_B, 32'h68 | (sz[k] & 4) | v >> 8);
			// enable lands, then the registered request follows
			repeat (2) @(posedge clk);
			chk("empty irq", 1, ibe);
			bus(1'b1, `OFS_CHAR_DATA, v);
			bus(1'b1, `OFS_CHAR_DATA, v ^ 32'hA5);
			rd(`OFS_CTRL_STATUS_A, db[k] << 1);
			n = 0;
			while (itc !== 1'b1 && n < 5000) begin
				@(posedge clk);
				n++;
			end
			chk("complete irq", 1, itc);
			frames(v, v ^ 32'hA5, pm[k]);
			if (k[0]) begin
				ack <= 1'b1;
				@(posedge clk);
				ack <= 1'b0;
			end else
				bus(1'b1, `OFS_CTRL_STATUS_A, 32'h40 | db[k] << 1);
			rd(`OFS_CTRL_STATUS_A, 32'h20 | db[k] << 1);
		end
		// disable while a frame runs and one waits
		bus(1'b1, `OFS_CHAR_DATA, 32'h3C);
		bus(1'b1, `OFS_CHAR_DATA, 32'hC3);
		bus(1'b1, `OFS_CTRL_STATUS_B, 32'h14 | v >> 8);
		chk("still owned", 1, tpo);
		n = 0;
		while (tpo !== 1'b0 && n < 5000) begin
			@(posedge clk);
			n++;
		end
		chk("released", 0, tpo);
		frames(32'h3C | (v & 32'h100), 32'hC3 | (v & 32'h100),
			pm[4]);
		chk("rx owned", 1, rpo);
		// sample well inside a steady stretch of the input
		@(sin);
		repeat (10) @(posedge clk);
		chk("rx data", sin, rsd);
		bus(1'b1, `OFS_FRAME_CFG, 32'h40);
		repeat (2) @(posedge clk);
		chk("clock pin", 1, cpo);
		report_and_stop();
	end
endmodule
